// >>> bench/flash_array_model.sv
// program array read side answering table reads
`timescale 1ns/100ps
`default_nettype none
module flash_array_model (
	input wire logic clk,
	input wire logic flashRdReq,
	input wire logic [21:0] flashRdAddr,
	output logic [7:0] flashRdData
);
	initial flashRdData = 8'h00;
	// byte valid only in the cycle after a request, inverted otherwise
	always @(posedge clk) begin
		if (flashRdReq)
			flashRdData <= flashRdAddr[7:0] ^ flashRdAddr[15:8] ^ {2'b00, flashRdAddr[21:16]};
		else
			flashRdData <= ~flashRdData;
	end
endmodule // flash_array_model
`default_nettype wire

// >>> bench/pflash_ctrl_checker.sv
// concurrent checks on the flash controller ports
`timescale 1ns/100ps
`default_nettype none
`include "pflash_ctrl_regs.svh"
module pflash_ctrl_checker
	import pflash_ctrl_pkg::*;
#(
	parameter int ERASE_CYCLES = 20,
	parameter int WRITE_CYCLES = 20
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic extResetReq,
	input wire logic wdtResetReq,
	input wire logic [11:0] regAddr,
	input wire logic regRd,
	input wire logic [7:0] regRdata,
	input wire logic flashRdReq,
	input wire logic progStart,
	input wire nvm_req_t progReq,
	input wire logic eeReadStrobe,
	input wire logic fetchStall,
	input wire logic doneIrq
);
	localparam int MAXC = (ERASE_CYCLES > WRITE_CYCLES ? ERASE_CYCLES : WRITE_CYCLES) + 3;
	int stallCnt_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) stallCnt_q <= 0;
		else stallCnt_q <= fetchStall ? stallCnt_q + 1 : 0;
	end
	sequence seqFlashStart;
		progStart && progReq.space == SPACE_FLASH;
	endsequence
	sequence seqStallRun;
		fetchStall [*8];
	endsequence
	// a warm reset legally cuts the stall short
	chk_start_stall: assert property (disable iff (!reset_n || extResetReq || wdtResetReq)
		seqFlashStart |=> seqStallRun)
		else $error("fetch not stalled after flash start");
	chk_stall_bound: assert property (stallCnt_q <= MAXC)
		else $error("stall outlasts timer");
	chk_start_pulse: assert property (progStart |=> !progStart)
		else $error("start not a single pulse");
	chk_done_stall: assert property ($rose(doneIrq) && $past(fetchStall) |-> !fetchStall)
		else $error("done flag and stall release apart");
	chk_erase_flash: assert property (progStart && progReq.erase |-> progReq.space == SPACE_FLASH)
		else $error("erase outside flash");
	chk_unlock_zero: assert property (regRd && regAddr == `ADDR_UNLOCK_PORT |=> regRdata == 8'h00)
		else $error("unlock port read nonzero");
	chk_read_pulse: assert property (flashRdReq |=> !flashRdReq)
		else $error("array read not one byte");
	chk_ee_pulse: assert property (eeReadStrobe |=> !eeReadStrobe)
		else $error("eeprom read longer than one cycle");
endmodule // pflash_ctrl_checker
`default_nettype wire

// >>> bench/program_flash_self_access_control_tb_top.sv
// self-checking bench for the flash self-access controller
`timescale 1ns/100ps
`default_nettype none
`include "pflash_ctrl_regs.svh"
module program_flash_self_access_control_tb_top
	import pflash_ctrl_pkg::*;
;
	localparam int NCYC = 20;
	logic clk = 0, reset_n = 0, extResetReq = 0, wdtResetReq = 0, regWr = 0, regRd = 0;
	logic [11:0] regAddr = '0;
	logic [7:0] regWdata = '0, regRdata, flashRdData, c;
	logic flashRdReq, progStart, eeReadStrobe, fetchStall, doneIrq;
	logic [21:0] flashRdAddr, ptr;
	nvm_req_t progReq, lastReq;
	logic [63:0] progData, lastData, blk;
	logic [7:0] ctl [4] = '{8'h84, 8'h94, 8'h04, 8'hc4};
	space_t sp [4] = '{SPACE_FLASH, SPACE_FLASH, SPACE_EEPROM, SPACE_CONFIG};
	int nMismatch = 0, numChecks = 0, nStart = 0, nEe = 0, cyc = 0;
	program_flash_self_access_control #(.ERASE_CYCLES(NCYC), .WRITE_CYCLES(NCYC))
		u_program_flash_self_access_control (
		.clk(clk), .reset_n(reset_n), .extResetReq(extResetReq), .wdtResetReq(wdtResetReq),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .flashRdReq(flashRdReq), .flashRdAddr(flashRdAddr),
		.flashRdData(flashRdData), .progStart(progStart), .progReq(progReq),
		.progData(progData), .eeReadStrobe(eeReadStrobe), .fetchStall(fetchStall),
		.doneIrq(doneIrq));
	flash_array_model u_flash_array_model (.clk(clk), .flashRdReq(flashRdReq),
		.flashRdAddr(flashRdAddr), .flashRdData(flashRdData));
	initial forever #12.5 clk = ~clk;
	function automatic logic [7:0] romB(logic [21:0] a);
		return a[7:0] ^ a[15:8] ^ {2'b00, a[21:16]};
	endfunction
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", numChecks, nMismatch);
		if (nMismatch == 0 && numChecks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (progStart) begin
			nStart <= nStart + 1;
			lastReq <= progReq;
			lastData <= progData;
		end
		if (eeReadStrobe) nEe <= nEe + 1;
		if (cyc == 5000) begin
			nMismatch = nMismatch + 1;
			print_verdict();
		end
	end
	task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
		numChecks++;
		if (got !== exp) begin
			nMismatch++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(logic [11:0] a, logic [7:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rdc(logic [11:0] a, logic [7:0] e, string what);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 chk(what, e, regRdata);
	endtask
	task automatic setp(logic [21:0] p);
		wr(`ADDR_PTR_LOW, p[7:0]);
		wr(`ADDR_PTR_HIGH, p[15:8]);
		wr(`ADDR_PTR_UPPER, {2'b00, p[21:16]});
	endtask
	// unlock pair then control write, then let the start monitor settle
	task automatic trig(logic [7:0] v);
		wr(`ADDR_UNLOCK_PORT, `UNLOCK_FIRST);
		wr(`ADDR_UNLOCK_PORT, `UNLOCK_SECOND);
		wr(`ADDR_ACCESS_CTRL, v);
		repeat (2) @(posedge clk);
	endtask
	initial begin
		ptr = 22'($urandom(32'ha86e_ec8e));
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		rdc(`ADDR_ACCESS_CTRL, `RESET_BYTE, "ctrl reset");
		wr(`ADDR_UNLOCK_PORT, `UNLOCK_FIRST);
		rdc(`ADDR_UNLOCK_PORT, 8'h00, "unlock port");
		rdc(12'hf00, 8'h00, "unmapped");
		wr(`ADDR_ACCESS_CTRL, 8'h80);
		trig(8'h82);
		chk("start no permit", 0, nStart);
		wr(`ADDR_ACCESS_CTRL, 8'h84);
		wr(`ADDR_ACCESS_CTRL, 8'h86);
		repeat (2) @(posedge clk);
		chk("start no unlock", 0, nStart);
		setp(ptr);
		for (int m = 0; m < 4; m++) begin
			wr(`ADDR_TABLE_OP, 8'(m));
			repeat (2) @(posedge clk);
			// pointer modes move only the low 21 bits
			if (m == 3) ptr[20:0] = ptr[20:0] + 21'h0_0001;
			rdc(`ADDR_BYTE_LATCH, romB(ptr), "table latch");
			if (m == 1) ptr[20:0] = ptr[20:0] + 21'h0_0001;
			if (m == 2) ptr[20:0] = ptr[20:0] - 21'h0_0001;
		end
		ptr = 22'($urandom) & 22'h3f_fff8;
		setp(ptr);
		for (int i = 0; i < 8; i++) begin
			blk[i*8 +: 8] = 8'($urandom);
			wr(`ADDR_BYTE_LATCH, blk[i*8 +: 8]);
			wr(`ADDR_TABLE_OP, i < 7 ? 8'h05 : 8'h04);
		end
		ptr = ptr + 22'd7;
		for (int k = 0; k < 4; k++) begin
			c = ctl[k];
			wr(`ADDR_ACCESS_CTRL, c);
			trig(c | 8'h02);
			chk("start count", k + 1, nStart);
			chk("op space", sp[k], lastReq.space);
			chk("op erase", c[4], lastReq.erase);
			if (k < 2) chk("stall", 1, fetchStall);
			if (k == 0) chk("block data", blk, lastData);
			if (k == 0) chk("block addr", ptr[21:3], lastReq.addr[21:3]);
			if (k == 1) chk("erase row", ptr[21:6], lastReq.addr[21:6]);
			wr(`ADDR_ACCESS_CTRL, c);
			rdc(`ADDR_ACCESS_CTRL, c | 8'h02, "trigger held");
			for (int i = 0; i < 4 * NCYC && doneIrq !== 1'b1; i++) @(negedge clk);
			chk("done irq", 1, doneIrq);
			rdc(`ADDR_ACCESS_CTRL, c & 8'hef, "ctrl after op");
			rdc(`ADDR_IRQ_FLAGS, 8'h10, "done flag");
			wr(`ADDR_IRQ_FLAGS, 8'h00);
			rdc(`ADDR_IRQ_FLAGS, 8'h00, "done flag clear");
			chk("done irq low", 0, doneIrq);
		end
		// read trigger is judged against the select bits already held
		wr(`ADDR_ACCESS_CTRL, 8'h00);
		wr(`ADDR_ACCESS_CTRL, 8'h01);
		wr(`ADDR_ACCESS_CTRL, 8'h80);
		wr(`ADDR_ACCESS_CTRL, 8'h81);
		repeat (2) @(posedge clk);
		chk("eeprom reads", 1, nEe);
		rdc(`ADDR_ACCESS_CTRL, 8'h80, "read trigger");
		for (int k = 0; k < 2; k++) begin
			wr(`ADDR_ACCESS_CTRL, 8'h84);
			trig(8'h86);
			if (k == 0) extResetReq <= 1'b1;
			else wdtResetReq <= 1'b1;
			@(posedge clk);
			extResetReq <= 1'b0;
			wdtResetReq <= 1'b0;
			repeat (2) @(posedge clk);
			rdc(`ADDR_ACCESS_CTRL, 8'h88, "abort ctrl");
		end
		print_verdict();
	end
endmodule // program_flash_self_access_control_tb_top
bind program_flash_self_access_control pflash_ctrl_checker #(
	.ERASE_CYCLES(ERASE_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)) u_pflash_ctrl_checker (
	.clk(clk), .reset_n(reset_n), .extResetReq(extResetReq), .wdtResetReq(wdtResetReq),
	.regAddr(regAddr), .regRd(regRd), .regRdata(regRdata),
	.flashRdReq(flashRdReq), .progStart(progStart), .progReq(progReq),
	.eeReadStrobe(eeReadStrobe), .fetchStall(fetchStall), .doneIrq(doneIrq));
`default_nettype wire

// >>> rtl/flash_holding_buffer.sv
// eight byte holding registers for block programming
`timescale 1ns/100ps
`default_nettype none
`include "pflash_ctrl_regs.svh"
module flash_holding_buffer (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic writeEn,
	input wire logic [2:0] writeIdx,
	input wire logic [7:0] writeData,
	input wire logic clearAll,
	output logic [63:0] blockData
);
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_byte
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					blockData[i*8 +: 8] <= `ERASED_BYTE;
				end else if (clearAll) begin
					blockData[i*8 +: 8] <= `ERASED_BYTE;
				end else if (writeEn && writeIdx == 3'(i)) begin
					blockData[i*8 +: 8] <= writeData;
				end
			end
		end
	endgenerate
endmodule // flash_holding_buffer
`default_nettype wire

// >>> rtl/program_flash_self_access_control.sv
// self-access controller for program flash, data eeprom and config space
`timescale 1ns/100ps
`default_nettype none
`include "pflash_ctrl_regs.svh"
module program_flash_self_access_control
	import pflash_ctrl_pkg::*;
#(
	parameter int ERASE_CYCLES = `ERASE_TIME_US * `CLK_MHZ,
	parameter int WRITE_CYCLES = `WRITE_TIME_US * `CLK_MHZ
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic extResetReq,
	input wire logic wdtResetReq,
	input wire logic [11:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	output logic flashRdReq,
	output logic [21:0] flashRdAddr,
	input wire logic [7:0] flashRdData,
	output logic progStart,
	output nvm_req_t progReq,
	output logic [63:0] progData,
	output logic eeReadStrobe,
	output logic fetchStall,
	output logic doneIrq
);
	logic spaceSel_q;
	logic cfgSel_q;
	logic eraseEn_q;
	logic abortFlag_q;
	logic permit_q;
	logic wrTrig_q;
	logic rdTrig_q;
	logic doneFlag_q;
	logic [7:0] latch_q;
	logic [21:0] ptr_q;
	logic rdWait_q;
	logic eraseOp_q;
	unlock_t unlock_q;
	logic timerBusy;
	logic timerDone;
	logic [63:0] holdData;
	logic warmReset;
	logic wrCtrl;
	logic wrUnlock;
	logic wrOp;
	logic startOp;
	logic startRd;
	logic tableRd;
	logic tableWr;
	logic [21:0] ptrEff;
	logic [20:0] ptrLow;
	logic [`TIMER_W-1:0] timerCycles;
	ptr_mode_t opMode;

	assign warmReset = extResetReq | wdtResetReq;
	assign wrCtrl = regWr && regAddr == `ADDR_ACCESS_CTRL;
	assign wrUnlock = regWr && regAddr == `ADDR_UNLOCK_PORT;
	assign wrOp = regWr && regAddr == `ADDR_TABLE_OP && !timerBusy;
	assign opMode = ptr_mode_t'(regWdata[1:0]);
	assign tableRd = wrOp && !regWdata[`BIT_OP_WRITE];
	assign tableWr = wrOp && regWdata[`BIT_OP_WRITE];
	// pre-increment touches only the low 21 bits
	assign ptrLow = ptr_q[20:0] + 21'h0_0001;
	assign ptrEff = (opMode == PTR_PRE_INC) ? {ptr_q[21], ptrLow} : ptr_q;
	// trigger honoured only once, when unlocked and permitted
	assign startOp = wrCtrl && regWdata[`BIT_WR_TRIG] && !wrTrig_q && !timerBusy
		&& permit_q && unlock_q == UNLOCK_ARMED && !warmReset;
	// read trigger refused while flash or config space is selected
	assign startRd = wrCtrl && regWdata[`BIT_RD_TRIG] && !rdTrig_q && !spaceSel_q
		&& !cfgSel_q && !timerBusy && !warmReset;
	assign timerCycles = (spaceSel_q && regWdata[`BIT_ERASE_EN] && eraseEn_q)
		? `TIMER_W'(ERASE_CYCLES) : `TIMER_W'(WRITE_CYCLES);

	program_timer u_timer (
		.clk(clk),
		.reset_n(reset_n),
		.start(startOp),
		.abort(warmReset),
		.cycles(timerCycles),
		.busy(timerBusy),
		.done(timerDone)
	);

	flash_holding_buffer u_hold (
		.clk(clk),
		.reset_n(reset_n),
		.writeEn(tableWr && !warmReset),
		.writeIdx(ptrEff[2:0]),
		.writeData(latch_q),
		.clearAll(timerDone && !eraseOp_q),
		.blockData(holdData)
	);

	// space selects survive an aborting reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			spaceSel_q <= 1'b0;
			cfgSel_q <= 1'b0;
		end else if (warmReset) begin
			if (!timerBusy) begin
				spaceSel_q <= 1'b0;
				cfgSel_q <= 1'b0;
			end
		end else if (wrCtrl && !timerBusy) begin
			spaceSel_q <= regWdata[`BIT_SPACE_SEL];
			cfgSel_q <= regWdata[`BIT_CFG_SEL];
		end
	end

	// erase enable and write permit
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			eraseEn_q <= 1'b0;
			permit_q <= 1'b0;
		end else if (warmReset) begin
			eraseEn_q <= 1'b0;
			permit_q <= 1'b0;
		end else if (timerDone && eraseOp_q) begin
			eraseEn_q <= 1'b0;
		end else if (wrCtrl && !timerBusy) begin
			eraseEn_q <= regWdata[`BIT_ERASE_EN];
			permit_q <= regWdata[`BIT_PERMIT];
		end
	end

	// abort flag
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			abortFlag_q <= 1'b0;
		end else if (warmReset && timerBusy) begin
			abortFlag_q <= 1'b1;
		end else if (timerDone) begin
			abortFlag_q <= 1'b0;
		end else if (wrCtrl && !timerBusy) begin
			abortFlag_q <= regWdata[`BIT_ABORT_FLAG];
		end
	end

	// write trigger: set by software only, cleared by the timer's end or a warm reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wrTrig_q <= 1'b0;
		end else if (warmReset || timerDone) begin
			wrTrig_q <= 1'b0;
		end else if (startOp) begin
			wrTrig_q <= 1'b1;
		end
	end

	// read trigger holds for one cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdTrig_q <= 1'b0;
			eeReadStrobe <= 1'b0;
		end else begin
			rdTrig_q <= startRd;
			eeReadStrobe <= startRd;
		end
	end

	// completion flag: hardware set wins over software clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			doneFlag_q <= 1'b0;
		end else if (timerDone) begin
			doneFlag_q <= 1'b1;
		end else if (regWr && regAddr == `ADDR_IRQ_FLAGS) begin
			doneFlag_q <= regWdata[`BIT_DONE_IRQ];
		end
	end

	// unlock sequence tracker; the port itself holds no data
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			unlock_q <= UNLOCK_IDLE;
		end else if (warmReset || wrCtrl) begin
			unlock_q <= UNLOCK_IDLE;
		end else if (wrUnlock) begin
			case (unlock_q)
				UNLOCK_IDLE: begin
					unlock_q <= (regWdata == `UNLOCK_FIRST) ? UNLOCK_HALF : UNLOCK_IDLE;
				end
				UNLOCK_HALF: begin
					unlock_q <= (regWdata == `UNLOCK_SECOND) ? UNLOCK_ARMED : UNLOCK_IDLE;
				end
				default: begin
					unlock_q <= UNLOCK_IDLE;
				end
			endcase
		end
	end

	// table pointer, byte granular, auto-modify on low 21 bits
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ptr_q <= '0;
		end else if (warmReset) begin
			ptr_q <= '0;
		end else if (regWr && regAddr == `ADDR_PTR_LOW) begin
			ptr_q[7:0] <= regWdata;
		end else if (regWr && regAddr == `ADDR_PTR_HIGH) begin
			ptr_q[15:8] <= regWdata;
		end else if (regWr && regAddr == `ADDR_PTR_UPPER) begin
			ptr_q[21:16] <= regWdata[5:0];
		end else if (wrOp) begin
			case (opMode)
				PTR_POST_INC: ptr_q[20:0] <= ptrLow;
				PTR_POST_DEC: ptr_q[20:0] <= ptr_q[20:0] - 21'h0_0001;
				PTR_PRE_INC: ptr_q[20:0] <= ptrLow;
				default: ptr_q <= ptr_q;
			endcase
		end
	end

	// table read: one byte per operation into the latch
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flashRdReq <= 1'b0;
			flashRdAddr <= '0;
			rdWait_q <= 1'b0;
		end else begin
			flashRdReq <= tableRd && !warmReset;
			rdWait_q <= flashRdReq;
			if (tableRd) begin
				flashRdAddr <= ptrEff;
			end
		end
	end

	// byte latch: any value is accepted unchanged
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			latch_q <= `RESET_BYTE;
		end else if (rdWait_q) begin
			latch_q <= flashRdData;
		end else if (regWr && regAddr == `ADDR_BYTE_LATCH) begin
			latch_q <= regWdata;
		end
	end

	// timed operation launch; only block writes or 64-byte erases exist
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			progStart <= 1'b0;
			progReq <= '0;
			progData <= '0;
			eraseOp_q <= 1'b0;
		end else begin
			progStart <= startOp;
			if (startOp) begin
				eraseOp_q <= eraseEn_q && spaceSel_q && !cfgSel_q;
				progData <= holdData;
				progReq.space <= cfgSel_q ? SPACE_CONFIG
					: (spaceSel_q ? SPACE_FLASH : SPACE_EEPROM);
				progReq.erase <= eraseEn_q && spaceSel_q && !cfgSel_q;
				if (eraseEn_q && spaceSel_q && !cfgSel_q) begin
					progReq.addr <= {ptr_q[21:6], 6'h00};
				end else begin
					progReq.addr <= {ptr_q[21:3], 3'h0};
				end
			end
		end
	end

	// fetch stall mirrors the timer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fetchStall <= 1'b0;
			doneIrq <= 1'b0;
		end else begin
			fetchStall <= (startOp || timerBusy) && !timerDone && !warmReset;
			doneIrq <= timerDone || (doneFlag_q
				&& !(regWr && regAddr == `ADDR_IRQ_FLAGS && !regWdata[`BIT_DONE_IRQ]));
		end
	end

	// read data, valid the cycle after the strobe
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			regRdata <= '0;
		end else if (!regRd) begin
			regRdata <= '0;
		end else if (regAddr == `ADDR_ACCESS_CTRL) begin
			regRdata <= {spaceSel_q, cfgSel_q, 1'b0, eraseEn_q, abortFlag_q,
				permit_q, wrTrig_q, rdTrig_q};
		end else if (regAddr == `ADDR_BYTE_LATCH) begin
			regRdata <= latch_q;
		end else if (regAddr == `ADDR_PTR_LOW) begin
			regRdata <= ptr_q[7:0];
		end else if (regAddr == `ADDR_PTR_HIGH) begin
			regRdata <= ptr_q[15:8];
		end else if (regAddr == `ADDR_PTR_UPPER) begin
			regRdata <= {2'b00, ptr_q[21:16]};
		end else if (regAddr == `ADDR_IRQ_FLAGS) begin
			regRdata <= {3'b000, doneFlag_q, 4'h0};
		end else begin
			regRdata <= '0;
		end
	end
endmodule // program_flash_self_access_control
`default_nettype wire

// >>> rtl/program_timer.sv
// internal programming timer for timed writes and erases
`timescale 1ns/100ps
`default_nettype none
`include "pflash_ctrl_regs.svh"
module program_timer (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic abort,
	input wire logic [`TIMER_W-1:0] cycles,
	output logic busy,
	output logic done
);
	logic [`TIMER_W-1:0] count_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_q <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (abort) begin
				busy <= 1'b0;
				count_q <= '0;
			end else if (start && !busy) begin
				busy <= 1'b1;
				count_q <= cycles;
			end else if (busy) begin
				if (count_q <= `TIMER_W'(1)) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
				count_q <= count_q - `TIMER_W'(1);
			end
		end
	end
endmodule // program_timer
`default_nettype wire

// >>> shared/pflash_ctrl_pkg.sv
// types shared by the flash self-access controller
package pflash_ctrl_pkg;
	typedef enum logic [1:0] {
		PTR_KEEP,
		PTR_POST_INC,
		PTR_POST_DEC,
		PTR_PRE_INC
	} ptr_mode_t;
	typedef enum logic [1:0] {
		SPACE_EEPROM,
		SPACE_FLASH,
		SPACE_CONFIG
	} space_t;
	typedef enum {
		UNLOCK_IDLE,
		UNLOCK_HALF,
		UNLOCK_ARMED
	} unlock_t;
	typedef struct packed {
		logic erase;
		space_t space;
		logic [21:0] addr;
	} nvm_req_t;
endpackage

// >>> shared/pflash_ctrl_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef PFLASH_CTRL_REGS_SVH
`define PFLASH_CTRL_REGS_SVH
`define ADDR_ACCESS_CTRL 12'h0fa6
`define ADDR_UNLOCK_PORT 12'h0fa7
`define ADDR_IRQ_FLAGS 12'h0fa1
`define ADDR_BYTE_LATCH 12'h0ff5
`define ADDR_PTR_LOW 12'h0ff6
`define ADDR_PTR_HIGH 12'h0ff7
`define ADDR_PTR_UPPER 12'h0ff8
`define ADDR_TABLE_OP 12'h0ff9
`define BIT_SPACE_SEL 7
`define BIT_CFG_SEL 6
`define BIT_ERASE_EN 4
`define BIT_ABORT_FLAG 3
`define BIT_PERMIT 2
`define BIT_WR_TRIG 1
`define BIT_RD_TRIG 0
`define BIT_DONE_IRQ 4
`define BIT_OP_WRITE 2
`define UNLOCK_FIRST 8'h55
`define UNLOCK_SECOND 8'haa
`define RESET_BYTE 8'h00
`define ERASED_BYTE 8'hff
`define CLK_MHZ 40
`define ERASE_TIME_US 2000
`define WRITE_TIME_US 2000
`define TIMER_W 17
`endif
